// ===== logic/bfd_defines.vh
// constants for the backlight fault and diagnostic register bank
// assumes a 16-bit register port addressed by the printed byte offsets
`ifndef BFD_DEFINES_VH
`define BFD_DEFINES_VH
// ==========================================================
// register offsets
`define BFD_ADDR_W 8
`define BFD_OFS_STRING_FAULT 8'h12
`define BFD_OFS_STATE_DIAG 8'h14
`define BFD_OFS_PWM_IN_DIAG 8'h16
`define BFD_OFS_PWM_OUT_DIAG 8'h18
`define BFD_OFS_SINK_CODE_DIAG 8'h1a
`define BFD_OFS_BOOST_CODE_DIAG 8'h1c
// ==========================================================
// string fault register fields
`define BFD_BIT_BUS_TO_FLAG 14
`define BFD_BIT_BUS_TO_CLR 13
`define BFD_BIT_BAD_CFG_FLAG 12
`define BFD_BIT_BAD_CFG_CLR 11
`define BFD_BIT_SUM_FLAG 10
`define BFD_BIT_SUM_CLR 9
`define BFD_BIT_GND_SHORT 8
`define BFD_BIT_INT_SHORT 7
`define BFD_BIT_OPEN 6
`define BFD_CH_LSB 0
`define BFD_CH_MSB 3
// ==========================================================
// field widths and reset values
`define BFD_DATA_W 16
`define BFD_STATE_W 5
`define BFD_SINK_W 12
`define BFD_BOOST_W 11
`define BFD_CH_N 4
`define BFD_ZERO16 16'h0000
`define BFD_STATE_RST 5'h00
// ==========================================================
// control state codes
`define BFD_ST_DISABLED 5'h00
`define BFD_ST_REG_POWER_UP 5'h01
`define BFD_ST_MEM_READ 5'h02
`define BFD_ST_STANDBY 5'h03
`define BFD_ST_RAMP_FIRST 5'h04
`define BFD_ST_RAMP_LAST 5'h0f
`define BFD_ST_NORMAL 5'h10
`define BFD_ST_SHUTDOWN 5'h11
`define BFD_ST_ERROR_RETRY 5'h12
`define BFD_ST_ALL_FAILED 5'h13
`endif

// ===== logic/bfd_flag.v
// one latched fault flag with a write-both-bits clear
// assumes set pulses and write strobes are synchronous to clk_sys
`include "bfd_defines.vh"
module bfd_flag
(
   input wire clk_sys,
   input wire rstn,
   input wire set_evt,
   input wire clr_req,
   output reg flag_r
);
   reg flag_nxt;
   always @*
   begin
      flag_nxt = flag_r;
      if (clr_req)
      begin
         flag_nxt = 1'b0;
      end
      // set beats clear so an event in the clearing cycle survives
      if (set_evt)
      begin
         flag_nxt = 1'b1;
      end
   end
   always @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         flag_r <= 1'b0;
      end
      else
      begin
         flag_r <= flag_nxt;
      end
   end
endmodule

// ===== logic/bfd_diag_regs.v
// backlight fault status and diagnostic register bank
// assumes fault events and live values come from the driver core on clk_sys
// Notes on behaviour
// - a serial bus timeout sets a sticky flag at bit 14 of the string fault register.
// - writing 1 to a status bit and its clear bit together clears the flag and its interrupt.
// - an invalid string configuration sets bit 12, cleared with bit 11 the same way.
// - any open, internal short or ground short sets summary bit 10, cleared with bit 9.
// - a string shorted to ground shows in read-only bit 8.
// - internal short in bit 7 and open in bit 6 clear when the summary flag clears.
// - channel faults 1 to 4 read in bits 0 to 3.
// - the control state reads as a 5-bit code in the state register.
// - the measured input duty reads as a 16-bit value.
// - the applied output duty reads as a 16-bit value.
// - the 12-bit sink current code reads in bits 11 to 0, upper bits zero.
// - the 11-bit boost voltage code reads in bits 10 to 0, upper bits zero.
`include "bfd_defines.vh"
module bfd_diag_regs
(
   input wire clk_sys,
   input wire rstn,
   // register port
   input wire [`BFD_ADDR_W-1:0] reg_addr,
   input wire [`BFD_DATA_W-1:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [`BFD_DATA_W-1:0] reg_rdata_r,
   // fault events from the driver core, one-cycle pulses
   input wire bus_timeout_evt,
   input wire bad_string_cfg_evt,
   input wire string_ground_short_evt,
   input wire string_internal_short_evt,
   input wire string_open_evt,
   input wire [`BFD_CH_N-1:0] channel_fault_evt,
   // live values from the driver core
   input wire [`BFD_STATE_W-1:0] control_state_now,
   input wire [`BFD_DATA_W-1:0] pwm_in_duty,
   input wire [`BFD_DATA_W-1:0] pwm_out_duty,
   input wire [`BFD_SINK_W-1:0] sink_dac_code,
   input wire [`BFD_BOOST_W-1:0] boost_target_code,
   // fault interrupt, active low as on the pin
   output wire fault_irq_n
);
   // ==========================================================
   // write decode
   wire wr_fault;
   wire clr_bus_to;
   wire clr_bad_cfg;
   wire clr_sum;
   assign wr_fault = reg_wr && (reg_addr == `BFD_OFS_STRING_FAULT);
   // both bits high in one write, otherwise ignored
   assign clr_bus_to = wr_fault && reg_wdata[`BFD_BIT_BUS_TO_FLAG]
      && reg_wdata[`BFD_BIT_BUS_TO_CLR];
   assign clr_bad_cfg = wr_fault && reg_wdata[`BFD_BIT_BAD_CFG_FLAG]
      && reg_wdata[`BFD_BIT_BAD_CFG_CLR];
   assign clr_sum = wr_fault && reg_wdata[`BFD_BIT_SUM_FLAG]
      && reg_wdata[`BFD_BIT_SUM_CLR];
   // reserved bits 5 and 4 are not stored, so stray writes do nothing

   // ==========================================================
   // latched fault flags
   wire bus_to_flag;
   wire bad_string_cfg_flag;
   wire string_fault_summary_flag;
   wire string_ground_short_flag;
   wire string_internal_short_flag;
   wire string_open_flag;
   wire [`BFD_CH_N-1:0] channel_fault;
   wire any_string_evt;
   assign any_string_evt = string_ground_short_evt | string_internal_short_evt
      | string_open_evt;

   bfd_flag u_bus_to
   (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .set_evt(bus_timeout_evt),
      .clr_req(clr_bus_to),
      .flag_r(bus_to_flag)
   );
   bfd_flag u_bad_cfg
   (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .set_evt(bad_string_cfg_evt),
      .clr_req(clr_bad_cfg),
      .flag_r(bad_string_cfg_flag)
   );
   bfd_flag u_sum
   (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .set_evt(any_string_evt),
      .clr_req(clr_sum),
      .flag_r(string_fault_summary_flag)
   );
   // detail bits follow the summary clear; no clear bits of their own
   bfd_flag u_gnd
   (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .set_evt(string_ground_short_evt),
      .clr_req(clr_sum),
      .flag_r(string_ground_short_flag)
   );
   bfd_flag u_short
   (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .set_evt(string_internal_short_evt),
      .clr_req(clr_sum),
      .flag_r(string_internal_short_flag)
   );
   bfd_flag u_open
   (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .set_evt(string_open_evt),
      .clr_req(clr_sum),
      .flag_r(string_open_flag)
   );
   genvar gi;
   generate
      for (gi = 0; gi < `BFD_CH_N; gi = gi + 1)
      begin : g_ch
         bfd_flag u_ch
         (
            .clk_sys(clk_sys),
            .rstn(rstn),
            .set_evt(channel_fault_evt[gi]),
            .clr_req(clr_sum),
            .flag_r(channel_fault[gi])
         );
      end
   endgenerate

   // ==========================================================
   // interrupt
   // only the three clearable flags drive it; string details ride on the summary, channel faults do not
   assign fault_irq_n = ~(bus_to_flag | bad_string_cfg_flag
      | string_fault_summary_flag);

   // ==========================================================
   // fault register image
   reg [`BFD_DATA_W-1:0] fault_img;
   always @*
   begin
      fault_img = `BFD_ZERO16;
      fault_img[`BFD_BIT_BUS_TO_FLAG] = bus_to_flag;
      fault_img[`BFD_BIT_BAD_CFG_FLAG] = bad_string_cfg_flag;
      fault_img[`BFD_BIT_SUM_FLAG] = string_fault_summary_flag;
      fault_img[`BFD_BIT_GND_SHORT] = string_ground_short_flag;
      fault_img[`BFD_BIT_INT_SHORT] = string_internal_short_flag;
      fault_img[`BFD_BIT_OPEN] = string_open_flag;
      fault_img[`BFD_CH_MSB:`BFD_CH_LSB] = channel_fault;
   end

   // ==========================================================
   // live value capture
   // sampled every cycle so a read sees a value from one consistent edge
   reg [`BFD_STATE_W-1:0] state_r;
   reg [`BFD_DATA_W-1:0] pwm_in_r;
   reg [`BFD_DATA_W-1:0] pwm_out_r;
   reg [`BFD_SINK_W-1:0] sink_r;
   reg [`BFD_BOOST_W-1:0] boost_r;
   always @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         state_r <= `BFD_STATE_RST;
         pwm_in_r <= `BFD_ZERO16;
         pwm_out_r <= `BFD_ZERO16;
         sink_r <= {`BFD_SINK_W{1'b0}};
         boost_r <= {`BFD_BOOST_W{1'b0}};
      end
      else
      begin
         state_r <= control_state_now;
         pwm_in_r <= pwm_in_duty;
         pwm_out_r <= pwm_out_duty;
         sink_r <= sink_dac_code;
         boost_r <= boost_target_code;
      end
   end

   // ==========================================================
   // read path
   reg [`BFD_DATA_W-1:0] rdata_nxt;
   always @*
   begin
      rdata_nxt = `BFD_ZERO16;
      case (reg_addr)
         `BFD_OFS_STRING_FAULT:
            rdata_nxt = fault_img;
         `BFD_OFS_STATE_DIAG:
            rdata_nxt = {{(`BFD_DATA_W-`BFD_STATE_W){1'b0}}, state_r};
         `BFD_OFS_PWM_IN_DIAG:
            rdata_nxt = pwm_in_r;
         `BFD_OFS_PWM_OUT_DIAG:
            rdata_nxt = pwm_out_r;
         `BFD_OFS_SINK_CODE_DIAG:
            rdata_nxt = {{(`BFD_DATA_W-`BFD_SINK_W){1'b0}}, sink_r};
         `BFD_OFS_BOOST_CODE_DIAG:
            rdata_nxt = {{(`BFD_DATA_W-`BFD_BOOST_W){1'b0}}, boost_r};
         default:
            rdata_nxt = `BFD_ZERO16;
      endcase
   end
   // data stands only in the cycle after the read strobe, zero otherwise
   always @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         reg_rdata_r <= `BFD_ZERO16;
      end
      else if (reg_rd)
      begin
         reg_rdata_r <= rdata_nxt;
      end
      else
      begin
         reg_rdata_r <= `BFD_ZERO16;
      end
   end
endmodule

// ===== tb/bfd_diag_regs_properties.sv
// checker for the fault status and diagnostic register bank
// assumes one clock domain, reset synchronous and active low
`include "bfd_defines.vh"
module bfd_diag_regs_properties
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [`BFD_ADDR_W-1:0] reg_addr,
   input wire logic [`BFD_DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [`BFD_DATA_W-1:0] reg_rdata_r,
   input wire logic bus_timeout_evt,
   input wire logic bad_string_cfg_evt,
   input wire logic string_ground_short_evt,
   input wire logic string_internal_short_evt,
   input wire logic string_open_evt,
   input wire logic [`BFD_CH_N-1:0] channel_fault_evt,
   input wire logic [`BFD_STATE_W-1:0] control_state_now,
   input wire logic [`BFD_DATA_W-1:0] pwm_in_duty,
   input wire logic [`BFD_DATA_W-1:0] pwm_out_duty,
   input wire logic [`BFD_SINK_W-1:0] sink_dac_code,
   input wire logic [`BFD_BOOST_W-1:0] boost_target_code,
   input wire logic fault_irq_n
);
// ==========================================
// helpers
default clocking cb @(posedge clk_sys); endclocking
default disable iff (!rstn);
wire fw = reg_wr && reg_addr == `BFD_OFS_STRING_FAULT;
wire pair = fw && ((reg_wdata[14] & reg_wdata[13]) | (reg_wdata[12] & reg_wdata[11])
   | (reg_wdata[10] & reg_wdata[9]));
wire str_evt = string_ground_short_evt | string_internal_short_evt | string_open_evt;
wire any_evt = bus_timeout_evt | bad_string_cfg_evt | str_evt;
// capture one edge back must not have been under reset
sequence rd_at(a);
   reg_rd && reg_addr == a && $past(rstn);
endsequence
// ==========================================
// properties
chk_timeout_raises_irq:
   assert property (bus_timeout_evt |=> !fault_irq_n) else $error("timeout irq missing");
chk_cfg_raises_irq:
   assert property (bad_string_cfg_evt |=> !fault_irq_n) else $error("cfg irq missing");
chk_string_raises_irq:
   assert property (str_evt |=> !fault_irq_n) else $error("string irq missing");
chk_irq_holds_low:
   assert property (!fault_irq_n && !pair |=> !fault_irq_n) else $error("irq dropped");
chk_lone_clear_inert:
   assert property (!fault_irq_n && reg_wr && !pair |=> $stable(fault_irq_n))
      else $error("lone clear acted");
chk_full_clear_release:
   assert property (fw && reg_wdata[14:9] == 6'h3f && !any_evt |=> fault_irq_n)
      else $error("irq not released");
chk_state_read_back:
   assert property (rd_at(`BFD_OFS_STATE_DIAG) |=>
      reg_rdata_r == {11'h000, $past(control_state_now, 2)}) else $error("state read");
chk_pwm_in_read:
   assert property (rd_at(`BFD_OFS_PWM_IN_DIAG) |=> reg_rdata_r == $past(pwm_in_duty, 2))
      else $error("input duty read");
chk_pwm_out_read:
   assert property (rd_at(`BFD_OFS_PWM_OUT_DIAG) |=> reg_rdata_r == $past(pwm_out_duty, 2))
      else $error("output duty read");
chk_sink_code_read:
   assert property (rd_at(`BFD_OFS_SINK_CODE_DIAG) |=>
      reg_rdata_r == {4'h0, $past(sink_dac_code, 2)}) else $error("sink code read");
chk_boost_code_read:
   assert property (rd_at(`BFD_OFS_BOOST_CODE_DIAG) |=>
      reg_rdata_r == {5'h00, $past(boost_target_code, 2)}) else $error("boost code read");
// read data stands for one cycle only, so the port reads zero after a cycle without a read
chk_rdata_idle_zero:
   assert property (!reg_rd |=> reg_rdata_r == 16'h0000) else $error("read data not idle");
endmodule
bind bfd_diag_regs bfd_diag_regs_properties i_props (.clk_sys(clk_sys), .rstn(rstn),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata_r(reg_rdata_r), .bus_timeout_evt(bus_timeout_evt),
   .bad_string_cfg_evt(bad_string_cfg_evt), .string_ground_short_evt(string_ground_short_evt),
   .string_internal_short_evt(string_internal_short_evt), .string_open_evt(string_open_evt),
   .channel_fault_evt(channel_fault_evt), .control_state_now(control_state_now),
   .pwm_in_duty(pwm_in_duty), .pwm_out_duty(pwm_out_duty), .sink_dac_code(sink_dac_code),
   .boost_target_code(boost_target_code), .fault_irq_n(fault_irq_n));

// ===== tb/testbench.sv
// self-checking bench for the fault status and diagnostic register bank
// assumes the design answers reads one cycle later and events set flags next cycle
`include "bfd_defines.vh"
module testbench;
timeunit 1ns;
timeprecision 1ps;
// ==========================================
// stimulus and model state
logic clk_sys = 0, rstn = 0, reg_wr = 0, reg_rd = 0;
logic [7:0] reg_addr = 8'h00;
logic [15:0] reg_wdata = 16'h0000, pwm_in = 16'h0000, pwm_out = 16'h0000, sf = 16'h0000;
logic [8:0] ev = 9'h000;
logic [4:0] st = 5'h00;
logic [11:0] sink = 12'h000;
logic [10:0] boost = 11'h000;
logic [7:0] offs [7] = '{8'h12, 8'h14, 8'h16, 8'h18, 8'h1a, 8'h1c, 8'h20};
wire [15:0] rdata;
wire irq_n;
integer failures = 0, samples_checked = 0, i, j;
always #5 clk_sys = ~clk_sys;
bfd_diag_regs i_dut (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(rdata),
   .bus_timeout_evt(ev[8]), .bad_string_cfg_evt(ev[7]), .string_ground_short_evt(ev[6]),
   .string_internal_short_evt(ev[5]), .string_open_evt(ev[4]), .channel_fault_evt(ev[3:0]),
   .control_state_now(st), .pwm_in_duty(pwm_in), .pwm_out_duty(pwm_out),
   .sink_dac_code(sink), .boost_target_code(boost), .fault_irq_n(irq_n));
// ==========================================
// tasks
task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
   samples_checked++;
   if (seen !== exp)
   begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
   end
endtask
// one cycle of write strobe and event pulses; model clears first, so a set wins
task op(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [8:0] e);
   @(posedge clk_sys);
   reg_wr <= w;
   reg_addr <= a;
   reg_wdata <= d;
   ev <= e;
   @(posedge clk_sys);
   reg_wr <= 1'b0;
   ev <= 9'h000;
   if (w && a == 8'h12 && d[14] && d[13]) sf = sf & 16'hbfff;
   if (w && a == 8'h12 && d[12] && d[11]) sf = sf & 16'hefff;
   if (w && a == 8'h12 && d[10] && d[9]) sf = sf & 16'hfa30;
   sf = sf | (e[8] ? 16'h4000 : 16'h0000) | (e[7] ? 16'h1000 : 16'h0000);
   sf = sf | (e[6] ? 16'h0500 : 16'h0000) | (e[5] ? 16'h0480 : 16'h0000);
   sf = sf | (e[4] ? 16'h0440 : 16'h0000) | {12'h000, e[3:0]};
   #1 chk("irq", {15'h0000, irq_n}, {15'h0000, ~(sf[14] | sf[12] | sf[10])});
endtask
task rd(input logic [7:0] a, input logic [15:0] exp);
   @(posedge clk_sys);
   reg_rd <= 1'b1;
   reg_addr <= a;
   @(posedge clk_sys);
   reg_rd <= 1'b0;
   #1 chk($sformatf("reg %h", a), rdata, exp);
endtask
task finish_test;
   $display("checks %0d mismatches %0d", samples_checked, failures);
   if (failures == 0 && samples_checked > 0)
      $display("No errors found");
   else
      $display("Errors were found");
   $finish;
endtask
// ==========================================
// tests
initial
begin
   void'($urandom(13));
   repeat (6) @(posedge clk_sys);
   rstn <= 1'b1;
   for (i = 0; i < 7; i++) rd(offs[i], 16'h0000);
   $display("test reset done");
   // reserved bits 5 and 4 are always written as zero
   for (i = 0; i < 9; i++)
   begin
      op(1'b0, 8'h00, 16'h0000, 9'h001 << i);
      op(1'b1, 8'h12, 16'h2a00, 9'h000);
      rd(8'h12, sf);
      op(1'b1, 8'h12, 16'h7e00, 9'h000);
      rd(8'h12, sf);
   end
   op(1'b0, 8'h00, 16'h0000, 9'h1ff);
   for (j = 0; j < 3; j++)
   begin
      op(1'b1, 8'h12, 16'h6000 >> (2 * j), 9'h000);
      rd(8'h12, sf);
   end
   op(1'b1, 8'h12, 16'h6000, 9'h100);
   rd(8'h12, sf);
   op(1'b1, 8'h12, 16'h6000, 9'h000);
   $display("test fault flags done");
   for (i = 0; i < 20; i++)
   begin
      st <= i[4:0];
      pwm_in <= 16'($urandom);
      pwm_out <= 16'($urandom);
      sink <= 12'($urandom);
      boost <= 11'($urandom);
      op(1'b1, offs[i % 5 + 1], 16'hffff, 9'h000);
      rd(8'h14, {11'h000, st});
      rd(8'h16, pwm_in);
      rd(8'h18, pwm_out);
      rd(8'h1a, {4'h0, sink});
      rd(8'h1c, {5'h00, boost});
   end
   $display("test live values done");
   finish_test;
end
initial
begin
   #50000;
   failures++;
   finish_test;
end
endmodule
